// *** hdl/frm_top.sv ***
// Behaviour
// R1: New mark may replace old mark, repeatedly
// R2: Reader may leave retransmit mode anytime
// R3: Marked data re-read unlimited times
// R4: Double rate marks whole rising/falling pair
// R5: Falling-edge mark covers its whole pair
// R6: Standard timing: mark high, empty high enters
// R7: Entry edge marks output register word
// R8: Pair retransmit starts at rising unit
// R9: Mode held until mark sampled low
// R10: Rewind low rewinds read pointer to mark
// R11: Reader keeps read enable high before rewind
// R12: Empty low during setup, high resumes reads
// R13: Standard timing: every word needs read enable
// R14: Writes continue, never onto marked location
// R15: Fall-through: mark high, ready low enters
// R16: Fall-through: ready high, low, then load
// R17: First rewound word falls through unrequested
// R18: Reader keeps 1280 bits before mark
// R19: Write pointer never passes the mark
// R20: Data in 20 bits, or low 10
// R21: Empty low on rewind edge, high next
// R22: Ready high on rewind edge, low next
// R23: Fall-through only in single data rate
// R24: Double rate mark aligned to pair start

`include "frm_defs.svh"

`default_nettype none

module frm_top
    import frm_pkg::*;
#(
    parameter int DEPTH = `FRM_DEPTH_UNITS,
    parameter int W     = `FRM_WIDE_W,
    parameter int NW    = `FRM_NARROW_W
) (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire logic           ce,
    // Configuration straps, caught after reset
    input  wire logic           fall_through_mode,
    input  wire logic           double_rate_mode,
    input  wire logic           input_width_sel,
    // Write port
    input  wire logic           write_en_n,
    input  wire logic [W-1:0]   write_data_in,
    // Read port controls
    input  wire logic           read_en_n,
    input  wire logic           mark,
    input  wire logic           rewind_req_n,
    // Read data and flags
    output logic      [2*W-1:0] read_data_out,
    output logic                empty_flag_n,
    output logic                output_ready_n,
    output logic                full_flag_n,
    output logic                retransmit_mode
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] ONE_U   = (AW+1)'(1);
    localparam logic [AW:0] TWO_U   = (AW+1)'(2);
    localparam logic [AW:0] DEPTH_U = (AW+1)'(DEPTH);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    frm_cfg_t    cfg_reg;
    logic        cfg_done_reg;
    frm_state_t  state_reg, state_next;
    logic [AW:0] wr_ptr_reg, wr_ptr_next;
    logic [AW:0] rd_ptr_reg, rd_ptr_next;
    logic [AW:0] mark_ptr_reg, mark_ptr_next;
    logic [AW:0] out_addr_reg, out_addr_next;
    logic        marked_reg, marked_next;
    logic        out_valid_reg, out_valid_next;
    logic [2*W-1:0] data_reg, data_next;
    logic        empty_reg, empty_next;
    logic        ready_reg, ready_next;
    logic        full_reg, full_next;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    frm_rd_ctl_t ctl;
    frm_cfg_t    cfg_in;
    logic        run;
    logic [AW:0] unit;
    logic [AW:0] avail;
    logic [AW:0] used;
    logic        have_unit;
    logic        wr_ok;
    logic        enter_ok;
    logic        mark_go;
    logic        rt_go;
    logic        std_read;
    logic        ft_load;
    logic        load_go;
    logic [AW:0] mark_addr;
    logic [W-1:0] wr_data_m;
    logic [W-1:0] rd_data0;
    logic [W-1:0] rd_data1;
    logic [AW:0] rd_ptr_p1;
    logic [AW:0] avail_next;
    logic [AW:0] used_next;

    assign ctl    = '{read_en_n: read_en_n, mark: mark, rewind_req_n: rewind_req_n};
    // Fall-through forces single data rate
    assign cfg_in = '{fall_through: fall_through_mode,
                      double_rate:  double_rate_mode & ~fall_through_mode, // [R23]
                      wide_input:   input_width_sel};
    assign run    = ce & cfg_done_reg;

    // Read unit is one word, or a rising/falling pair
    assign unit      = cfg_reg.double_rate ? TWO_U : ONE_U; // [R4]
    assign avail     = wr_ptr_reg - rd_ptr_reg;
    assign have_unit = avail >= unit;

    // Fill measured from the mark while one is held
    assign used  = wr_ptr_reg - (marked_reg ? mark_ptr_reg : rd_ptr_reg); // [R19]
    assign wr_ok = ~write_en_n & (used != DEPTH_U); // [R14]

    // Narrow input keeps only the low bits
    assign wr_data_m = cfg_reg.wide_input ? write_data_in
                                          : {{(W-NW){1'b0}}, write_data_in[NW-1:0]}; // [R20]

    // Retransmit mode entry condition per timing mode
    assign enter_ok = cfg_reg.fall_through ? ~ready_reg // [R15]
                                           : empty_reg; // [R6]
    assign mark_go  = ctl.mark & ~marked_reg & enter_ok;

    // Double rate mark snaps to rising unit of the pair
    assign mark_addr = cfg_reg.double_rate ? (out_addr_reg & ~ONE_U) // [R5] [R24]
                                           : out_addr_reg;

    // Rewind accepted only with a mark held
    assign rt_go = ~ctl.rewind_req_n & marked_reg & ctl.mark // [R10]
                   & (state_reg == FRM_ST_IDLE);

    // Standard timing: every word requested, none during setup
    assign std_read = ~cfg_reg.fall_through & ~ctl.read_en_n & have_unit // [R13]
                      & (state_reg == FRM_ST_IDLE) & ~rt_go;

    // Fall-through: fill an empty output or pop on request
    assign ft_load = cfg_reg.fall_through & have_unit & ~rt_go
                     & (((state_reg == FRM_ST_IDLE) & (~out_valid_reg | ~ctl.read_en_n))
                        | (state_reg == FRM_ST_LOAD)); // [R17]

    assign load_go   = std_read | ft_load;
    assign rd_ptr_p1 = rd_ptr_reg + ONE_U;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    frm_mem #(
        .W  (W),
        .AW (AW)
    ) u_mem (
        .ref_clk  (ref_clk),
        .ce       (run),
        .wr_en    (wr_ok),
        .wr_addr  (wr_ptr_reg[AW-1:0]),
        .wr_data  (wr_data_m),
        .rd_addr0 (rd_ptr_reg[AW-1:0]),
        .rd_addr1 (rd_ptr_p1[AW-1:0]),
        .rd_data0 (rd_data0),
        .rd_data1 (rd_data1)
    );

    // ------------------------------------------------------------
    // Mark, rewind and read sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_next     = state_reg;
        wr_ptr_next    = wr_ptr_reg + (wr_ok ? ONE_U : '0);
        rd_ptr_next    = rd_ptr_reg;
        mark_ptr_next  = mark_ptr_reg;
        out_addr_next  = out_addr_reg;
        marked_next    = marked_reg;
        out_valid_next = out_valid_reg;
        data_next      = data_reg;

        // Entry captures the output register location; drop ends mode
        if (mark_go) begin
            marked_next   = 1'b1;
            mark_ptr_next = mark_addr; // [R7] [R1]
        end else if (~ctl.mark) begin
            marked_next   = 1'b0; // [R2] [R9]
        end

        // Load output register, pair in upper and lower halves
        if (load_go) begin
            data_next      = cfg_reg.double_rate ? {rd_data1, rd_data0}
                                                 : {{W{1'b0}}, rd_data0};
            out_addr_next  = rd_ptr_reg;
            rd_ptr_next    = rd_ptr_reg + unit;
            out_valid_next = 1'b1;
        end else if (cfg_reg.fall_through & ~ctl.read_en_n & (state_reg == FRM_ST_IDLE)) begin
            out_valid_next = 1'b0;
        end

        case (state_reg)
            FRM_ST_IDLE: begin
                // Rewind to the pair start, any number of times
                if (rt_go) begin
                    rd_ptr_next    = mark_ptr_reg; // [R3] [R8]
                    out_valid_next = 1'b0;
                    state_next     = FRM_ST_SETUP;
                end
            end
            FRM_ST_SETUP: begin
                state_next = cfg_reg.fall_through ? FRM_ST_LOAD : FRM_ST_IDLE; // [R21]
            end
            FRM_ST_LOAD: begin
                // Marked word falls through without read enable
                if (ft_load) begin
                    state_next = FRM_ST_IDLE; // [R16]
                end
            end
            default: begin
                state_next = FRM_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Flag next values from next pointers
    // ------------------------------------------------------------
    assign avail_next = wr_ptr_next - rd_ptr_next;
    assign used_next  = wr_ptr_next - (marked_next ? mark_ptr_next : rd_ptr_next);

    always_comb begin
        // Empty low through setup, high once words are there
        empty_next = ~cfg_reg.fall_through & (state_next == FRM_ST_IDLE)
                     & (avail_next >= unit); // [R12] [R21]
        // Ready high in setup, low from the next edge
        case (state_next)
            FRM_ST_SETUP: ready_next = 1'b1; // [R22]
            FRM_ST_LOAD:  ready_next = 1'b0; // [R16]
            default:      ready_next = ~(cfg_reg.fall_through & out_valid_next);
        endcase
        full_next = used_next != DEPTH_U;
    end

    // ------------------------------------------------------------
    // Strap capture, one edge after reset release
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg      <= '0;
            cfg_done_reg <= 1'b0;
        end else if (ce && !cfg_done_reg) begin
            cfg_reg      <= cfg_in;
            cfg_done_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pointers and sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= FRM_ST_IDLE;
            wr_ptr_reg    <= (AW+1)'(`FRM_PTR_RST);
            rd_ptr_reg    <= (AW+1)'(`FRM_PTR_RST);
            mark_ptr_reg  <= (AW+1)'(`FRM_PTR_RST);
            out_addr_reg  <= (AW+1)'(`FRM_PTR_RST);
            marked_reg    <= 1'b0;
            out_valid_reg <= 1'b0;
        end else if (run) begin
            state_reg     <= state_next;
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            mark_ptr_reg  <= mark_ptr_next;
            out_addr_reg  <= out_addr_next;
            marked_reg    <= marked_next;
            out_valid_reg <= out_valid_next;
        end
    end

    // ------------------------------------------------------------
    // Output register and flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg  <= (2*W)'(`FRM_OUT_RST);
            empty_reg <= 1'b0;
            ready_reg <= 1'b1;
            full_reg  <= 1'b1;
        end else if (run) begin
            data_reg  <= data_next;
            empty_reg <= empty_next;
            ready_reg <= ready_next;
            full_reg  <= full_next;
        end
    end

    // Outputs straight from flip-flops
    assign read_data_out   = data_reg;
    assign empty_flag_n    = empty_reg;
    assign output_ready_n  = ready_reg;
    assign full_flag_n     = full_reg;
    assign retransmit_mode = marked_reg;

endmodule // frm_top

`default_nettype wire

// *** hdl/frm_defs.svh ***
`ifndef FRM_DEFS_SVH
`define FRM_DEFS_SVH

// ----------------------------------------------------------------
// Widths and depth
// ----------------------------------------------------------------
`define FRM_WIDE_W        20
`define FRM_NARROW_W      10
`define FRM_DEPTH_UNITS   256

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FRM_OUT_RST       40'h00_0000_0000
`define FRM_PTR_RST       0

// ----------------------------------------------------------------
// Reader spacing between write pointer and mark, in bits
// ----------------------------------------------------------------
`define FRM_MARK_GAP_BITS 1280
`define FRM_MARK_GAP_WIDE (`FRM_MARK_GAP_BITS / `FRM_WIDE_W)
`define FRM_MARK_GAP_NARR (`FRM_MARK_GAP_BITS / `FRM_NARROW_W)

`endif

// *** hdl/frm_pkg.sv ***
`default_nettype none

package frm_pkg;

    // ------------------------------------------------------------
    // Retransmit sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FRM_ST_IDLE  = 3'b001,
        FRM_ST_SETUP = 3'b010,
        FRM_ST_LOAD  = 3'b100
    } frm_state_t;

    // ------------------------------------------------------------
    // Configuration caught once after reset release
    // ------------------------------------------------------------
    typedef struct packed {
        logic fall_through;
        logic double_rate;
        logic wide_input;
    } frm_cfg_t;

    // ------------------------------------------------------------
    // Reader controls sampled on each read clock edge
    // ------------------------------------------------------------
    typedef struct packed {
        logic read_en_n;
        logic mark;
        logic rewind_req_n;
    } frm_rd_ctl_t;

endpackage

`default_nettype wire

// *** hdl/frm_mem.sv ***
`default_nettype none

// Flip-flop storage, one write port, two combinational read ports
module frm_mem
    import frm_pkg::*;
#(
    parameter int W  = 20,
    parameter int AW = 8
) (
    // Clock
    input  wire logic          ref_clk,
    input  wire logic          ce,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read ports
    input  wire logic [AW-1:0] rd_addr0,
    input  wire logic [AW-1:0] rd_addr1,
    output logic      [W-1:0]  rd_data0,
    output logic      [W-1:0]  rd_data1
);

    logic [W-1:0] mem_reg [2**AW];

    // ------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------
    // No reset: contents are only read after being written
    always_ff @(posedge ref_clk) begin
        if (ce && wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // Read selection
    assign rd_data0 = mem_reg[rd_addr0];
    assign rd_data1 = mem_reg[rd_addr1];

endmodule // frm_mem

`default_nettype wire

// *** hdl/frm_top_note_unused.sv ***
`default_nettype none
`default_nettype wire

// *** tb/frm_top_monitor.sv ***
`default_nettype none
// ----------------------------------------------------------------
// Retransmit mode and flag checks
// ----------------------------------------------------------------
module frm_top_monitor #(
    parameter int W = 20
) (
    // Clock and reset
    input wire logic           ref_clk,
    input wire logic           rst_n,
    input wire logic           ce,
    // Straps
    input wire logic           fall_through_mode,
    input wire logic           input_width_sel,
    // Reader controls
    input wire logic           mark,
    input wire logic           rewind_req_n,
    // Read side outputs
    input wire logic [2*W-1:0] read_data_out,
    input wire logic           empty_flag_n,
    input wire logic           output_ready_n,
    input wire logic           retransmit_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Rewind request seen while marked
    wire logic rw_go = ce && !rewind_req_n && mark && retransmit_mode;
    wire logic enter = ce && mark && !retransmit_mode;

    // Flag pulses around setup
    a_rewind_empty_pulse: assert property (
        rw_go && !fall_through_mode && empty_flag_n |=> !empty_flag_n ##1 empty_flag_n)
        else $error("empty flag pulse wrong after rewind");
    a_rewind_ready_pulse: assert property (
        rw_go && fall_through_mode && !output_ready_n |=> output_ready_n ##1 !output_ready_n)
        else $error("ready flag pulse wrong after rewind");
    // Entry into and exit from retransmit mode
    a_mark_enter_std: assert property (
        enter && !fall_through_mode && empty_flag_n |=> retransmit_mode)
        else $error("standard mark not taken");
    a_mark_enter_ft: assert property (
        enter && fall_through_mode && !output_ready_n |=> retransmit_mode)
        else $error("fall-through mark not taken");
    a_mark_exit_low: assert property (
        ce && !mark |=> !retransmit_mode)
        else $error("mode kept with mark low");
    a_mark_hold_on: assert property (
        ce && mark && retransmit_mode |=> retransmit_mode)
        else $error("mode lost with mark high");
    // Output register guarded while empty
    a_setup_no_read: assert property (
        ce && !fall_through_mode && !empty_flag_n |=> $stable(read_data_out))
        else $error("output changed while empty flag low");
    // Width and rate limits on the output
    a_ft_single_rate: assert property (
        fall_through_mode |-> read_data_out[2*W-1:W] == '0)
        else $error("second unit used in fall-through");
    a_narrow_upper: assert property (
        !input_width_sel |-> read_data_out[W-1:10] == '0 && read_data_out[2*W-1:W+10] == '0)
        else $error("upper bits set in narrow input");
    // Main scenarios reached
    c_rewind_std: cover property (rw_go && !fall_through_mode);
    c_rewind_ft: cover property (rw_go && fall_through_mode);
    c_mark_taken: cover property (enter ##1 retransmit_mode);
endmodule // frm_top_monitor

bind frm_top frm_top_monitor #(.W(W)) mon_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .fall_through_mode(fall_through_mode), .input_width_sel(input_width_sel), .mark(mark),
    .rewind_req_n(rewind_req_n), .read_data_out(read_data_out), .empty_flag_n(empty_flag_n),
    .output_ready_n(output_ready_n), .retransmit_mode(retransmit_mode));
`default_nettype wire

// *** tb/frm_reader_model.sv ***
`default_nettype none
// ----------------------------------------------------------------
// Reader on the far side of the read port
// ----------------------------------------------------------------
module frm_reader_model (
    // Clock
    input  wire logic ref_clk,
    // Read controls
    output var logic  read_en_n,
    output var logic  mark,
    output var logic  rewind_req_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle reader
    initial begin
        read_en_n    = 1'b1;
        mark         = 1'b0;
        rewind_req_n = 1'b1;
    end
    // One read request per read unit
    task automatic read_unit();
        @(posedge ref_clk);
        read_en_n <= 1'b0;
        @(posedge ref_clk);
        read_en_n <= 1'b1;
    endtask
    // One-cycle rewind, reads already held off
    task automatic rewind();
        @(posedge ref_clk);
        rewind_req_n <= 1'b0;
        @(posedge ref_clk);
        rewind_req_n <= 1'b1;
    endtask
    // Mark level held until changed
    task automatic hold_mark(input logic v);
        @(posedge ref_clk);
        mark <= v;
    endtask
endmodule // frm_reader_model
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
// ----------------------------------------------------------------
// Retransmit bench
// ----------------------------------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 20;
    logic           ref_clk = 1'b0;
    logic           rst_n = 1'b0;
    logic           ce = 1'b1;
    logic           fall_through_mode = 1'b0;
    logic           double_rate_mode = 1'b0;
    logic           input_width_sel = 1'b1;
    logic           write_en_n = 1'b1;
    logic [W-1:0]   write_data_in = '0;
    logic           read_en_n, mark, rewind_req_n;
    logic [2*W-1:0] read_data_out;
    logic           empty_flag_n, output_ready_n, full_flag_n, retransmit_mode;
    int             miscompares = 0;
    int             checks = 0;
    int             cycles = 0;

    // Clock and instances
    always #4 ref_clk = ~ref_clk;
    frm_reader_model rdr (.ref_clk, .read_en_n, .mark, .rewind_req_n);
    frm_top #(.DEPTH(256)) dut_u (.ref_clk, .rst_n, .ce, .fall_through_mode, .double_rate_mode,
        .input_width_sel, .write_en_n, .write_data_in, .read_en_n, .mark, .rewind_req_n,
        .read_data_out, .empty_flag_n, .output_ready_n, .full_flag_n, .retransmit_mode);

    // Compare and report
    task automatic chk_data(input string what, input logic [2*W-1:0] exp, got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Stimulus steps
    task automatic do_reset(input logic ft, ddr, wide);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        fall_through_mode <= ft;
        double_rate_mode <= ddr;
        input_width_sel <= wide;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic wr_burst(input logic [W-1:0] base, input int n);
        @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            write_en_n <= 1'b0;
            write_data_in <= base + W'(i);
            @(posedge ref_clk);
        end
        write_en_n <= 1'b1;
    endtask
    task automatic wait_avail();
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (k < 8 && !(fall_through_mode ? output_ready_n === 1'b0 : empty_flag_n === 1'b1));
        chk_flag("data available", 1'b1, k < 8);
    endtask
    task automatic rd_exp(input logic [2*W-1:0] exp);
        rdr.read_unit();
        #1;
        chk_data("read data", exp, read_data_out);
    endtask
    task automatic mark_to(input logic v);
        rdr.hold_mark(v);
        @(posedge ref_clk);
        #1;
        chk_flag("retransmit mode", v, retransmit_mode);
    endtask
    task automatic do_rewind();
        rdr.rewind();
        #1;
        chk_flag("setup flag", 1'b0, fall_through_mode ? ~output_ready_n : empty_flag_n);
        @(posedge ref_clk);
        #1;
        chk_flag("setup flag", 1'b1, fall_through_mode ? ~output_ready_n : empty_flag_n);
    endtask

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            results();
        end
    end

    // Test sequence
    initial begin
        do_reset(1'b0, 1'b0, 1'b1);
        wr_burst(20'h01000, 8);
        wait_avail();
        rd_exp(40'h01000);
        rd_exp(40'h01001);
        mark_to(1'b1);
        rd_exp(40'h01002);
        rd_exp(40'h01003);
        wr_burst(20'h02000, 250);
        @(posedge ref_clk);
        #1;
        chk_flag("full flag", 1'b0, full_flag_n);
        do_rewind();
        for (int i = 0; i < 16; i++) begin
            rd_exp(i < 7 ? 40'(40'h01001 + i) : 40'(40'h02000 + i - 7));
        end
        do_rewind();
        rd_exp(40'h01001);
        mark_to(1'b0);
        rd_exp(40'h01002);
        mark_to(1'b1);
        rd_exp(40'h01003);
        do_rewind();
        rd_exp(40'h01002);
        mark_to(1'b0);
        // Fall-through timing, double rate strap overridden
        do_reset(1'b1, 1'b1, 1'b1);
        wr_burst(20'h03000, 70);
        wait_avail();
        chk_data("read data", 40'h03000, read_data_out);
        mark_to(1'b1);
        rd_exp(40'h03001);
        rd_exp(40'h03002);
        do_rewind();
        @(posedge ref_clk);
        #1;
        chk_data("read data", 40'h03000, read_data_out);
        @(posedge ref_clk);
        #1;
        chk_data("read data", 40'h03000, read_data_out);
        rd_exp(40'h03001);
        mark_to(1'b0);
        // Double rate, narrow input
        do_reset(1'b0, 1'b1, 1'b0);
        wr_burst(20'hffc00, 136);
        wait_avail();
        rd_exp({20'h00001, 20'h00000});
        rd_exp({20'h00003, 20'h00002});
        mark_to(1'b1);
        rd_exp({20'h00005, 20'h00004});
        do_rewind();
        rd_exp({20'h00003, 20'h00002});
        // Clock enable low freezes the read
        @(posedge ref_clk);
        ce <= 1'b0;
        rd_exp({20'h00003, 20'h00002});
        results();
    end
endmodule // tb_top
`default_nettype wire
